//--- design/esse_engine.sv
// Purpose: walks a byte-coded script and moves register bytes
// Assumes: script and register buffer answer one cycle after a read
// Notes:   save sends buffer bytes out, load writes array bytes in
//
// How it works
// - top bit clear means data transfer
// - low seven bits give length minus one
// - start address follows, high byte first
// - top bit set means operation code
// - commit op copies buffer into active registers
// - end op stops the walk, buffered save bytes drain before done
// - each entry selects its own register range
// - commit acts next edge, clears itself
`timescale 1ns/1ps
module esse_engine
#(
  parameter int DEPTH = esse_pkg::FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic save_sel,
  output logic busy,
  output logic done,
  output logic commit,
  output logic scr_rd,
  output logic [esse_pkg::SCR_AW-1:0] scr_addr,
  input wire logic [7:0] scr_data,
  output esse_pkg::esse_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  output esse_pkg::esse_byte_t ee_tx,
  input wire logic ee_tx_ready,
  input wire logic ee_rx_valid,
  input wire logic [7:0] ee_rx_data,
  output logic ee_rx_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD_RD, S_CMD_DEC, S_HI_RD, S_HI_GET,
    S_LO_RD, S_LO_GET, S_XFER, S_DRAIN
  } esse_state_t;

  localparam int AW = esse_pkg::ADDR_W;
  esse_state_t state_reg;                 // walker position
  esse_state_t state_next;
  logic save_reg;                         // direction of this walk
  logic [esse_pkg::SCR_AW-1:0] scr_addr_reg;  // script read pointer
  logic scr_rd_reg;
  logic [esse_pkg::CMD_LEN_W-1:0] len_reg;    // length minus one
  logic [7:0] hi_reg;                     // high address byte
  logic [AW-1:0] addr_reg;                // next register to touch
  logic [7:0] left_reg;                   // bytes still to read/write
  logic [7:0] rx_left_reg;                // array bytes still to take
  logic [7:0] rx_left_next;
  logic cap_reg;                          // register read data now
  esse_pkg::esse_reg_req_t reg_req_reg;
  esse_pkg::esse_byte_t tx_reg;
  logic commit_reg;
  logic done_reg;
  logic busy_reg;
  logic is_op;                            // decoded entry kind
  logic rd_issue;
  logic wr_pop;
  logic rx_take;
  logic tx_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_open;

  // join the two address bytes, high byte first
  function automatic logic [AW-1:0] mk_addr(input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[AW-1:0];
  endfunction

  assign busy = busy_reg;
  assign done = done_reg;
  assign commit = commit_reg;
  assign scr_rd = scr_rd_reg;
  assign scr_addr = scr_addr_reg;
  assign reg_req = reg_req_reg;
  assign ee_tx = tx_reg;
  assign ee_rx_ready = fifo_in_ready;

  // ----------------------------------------------------------------
  // decode and walk
  // ----------------------------------------------------------------
  assign is_op = scr_data[esse_pkg::CMD_KIND_POS];

  // one byte per read, one read at a time keeps the order exact
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
        if (start)
          state_next = S_CMD_RD;
      S_CMD_RD: state_next = S_CMD_DEC;
      S_CMD_DEC:
        if (!is_op)
          state_next = S_HI_RD;
        else if (scr_data == esse_pkg::OP_END)
          state_next = S_DRAIN;
        else
          state_next = S_CMD_RD;
      S_HI_RD: state_next = S_HI_GET;
      S_HI_GET: state_next = S_LO_RD;
      S_LO_RD: state_next = S_LO_GET;
      S_LO_GET: state_next = S_XFER;
      S_XFER:
        // next entry only once this range is fully moved
        if (left_reg == 8'h00 && !reg_req_reg.rd && !cap_reg)
          state_next = S_CMD_RD;
      S_DRAIN:
        if (!fifo_out_valid && !tx_reg.valid)
          state_next = S_IDLE;
    endcase
  end

  // walker state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // direction is caught once per walk
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      save_reg <= 1'b0;
    else if (state_reg == S_IDLE && start)
      save_reg <= save_sel;
  end

  // script pointer moves past every byte it consumes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scr_addr_reg <= esse_pkg::SCR_BASE;
      scr_rd_reg <= 1'b0;
    end
    else
    begin
      scr_rd_reg <= (state_next == S_CMD_RD) || (state_next == S_HI_RD)
        || (state_next == S_LO_RD);
      if (state_reg == S_IDLE)
        scr_addr_reg <= esse_pkg::SCR_BASE;
      else if (state_reg == S_CMD_DEC || state_reg == S_HI_GET
        || state_reg == S_LO_GET)
        scr_addr_reg <= scr_addr_reg + 8'h01;
    end
  end

  // entry fields
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      len_reg <= '0;
      hi_reg <= 8'h00;
    end
    else
    begin
      if (state_reg == S_CMD_DEC && !is_op)
        len_reg <= scr_data[esse_pkg::CMD_LEN_W-1:0];
      if (state_reg == S_HI_GET)
        hi_reg <= scr_data;
    end
  end

  // ----------------------------------------------------------------
  // data movement
  // ----------------------------------------------------------------
  assign rd_issue = state_reg == S_XFER && save_reg && left_reg != 8'h00
    && !reg_req_reg.rd && !cap_reg && fifo_in_ready;
  assign wr_pop = state_reg == S_XFER && !save_reg && fifo_out_valid;
  assign rx_take = ee_rx_valid && fifo_in_ready;
  assign tx_pop = save_reg && fifo_out_valid
    && (!tx_reg.valid || ee_tx_ready);
  assign rx_left_next = (state_reg == S_LO_GET) ? {1'b0, len_reg} + 8'h01
    : rx_left_reg - 8'(rx_take);
  // open only in a move, so idle never swallows array bytes;
  // loads stop at the announced count, a save move shows ready too
  assign fifo_open = state_next == S_XFER
    && (save_reg || rx_left_next != 8'h00);

  // range walk: start address and count pick the registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_reg <= '0;
      left_reg <= 8'h00;
      rx_left_reg <= 8'h00;
    end
    else
    begin
      rx_left_reg <= rx_left_next;
      if (state_reg == S_LO_GET)
      begin
        addr_reg <= mk_addr(hi_reg, scr_data);
        left_reg <= {1'b0, len_reg} + 8'h01;
      end
      else if (rd_issue || wr_pop)
      begin
        addr_reg <= addr_reg + AW'(1);
        left_reg <= left_reg - 8'h01;
      end
    end
  end

  // register buffer port, one access per cycle at most
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_req_reg <= '0;
      cap_reg <= 1'b0;
    end
    else
    begin
      cap_reg <= reg_req_reg.rd;
      reg_req_reg.rd <= rd_issue;
      reg_req_reg.wr <= wr_pop;
      if (rd_issue || wr_pop)
      begin
        reg_req_reg.addr <= addr_reg;
        reg_req_reg.wdata <= fifo_out_data;
      end
    end
  end

  // outbound stream stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_reg <= '0;
    else if (tx_pop)
      tx_reg <= {1'b1, fifo_out_data};
    else if (ee_tx_ready)
      tx_reg.valid <= 1'b0;
  end

  esse_fifo #(.WIDTH(esse_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(save_reg ? cap_reg : ee_rx_valid),
    .in_data(save_reg ? reg_rdata : ee_rx_data),
    .in_open(fifo_open),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(save_reg ? tx_pop : wr_pop)
  );

  // ----------------------------------------------------------------
  // commit and status
  // ----------------------------------------------------------------
  // commit is a single pulse; loads have finished writing by now
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      commit_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      commit_reg <= state_reg == S_CMD_DEC
        && scr_data == esse_pkg::OP_COMMIT;
      done_reg <= state_reg == S_DRAIN && state_next == S_IDLE;
      busy_reg <= state_next != S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_addr_bytes;
    state_reg == S_HI_GET ##2 state_reg == S_LO_GET;
  endsequence

  chk_commit_follows_op: assert property (
    state_reg == S_CMD_DEC && scr_data == esse_pkg::OP_COMMIT |=> commit_reg)
    else $error("commit op did not pulse commit");
  chk_commit_self_clear: assert property (
    commit_reg |=> !commit_reg)
    else $error("commit stayed high");
  chk_end_stops_walk: assert property (
    state_reg == S_CMD_DEC && scr_data == esse_pkg::OP_END
    |=> !scr_rd_reg [*2])
    else $error("script read after end op");
  chk_xfer_kind: assert property (
    state_reg == S_CMD_DEC && !is_op |=> scr_rd_reg && state_reg == S_HI_RD)
    else $error("transfer entry not followed by address read");
  chk_op_kind: assert property (
    state_reg == S_CMD_DEC && is_op |=> state_reg != S_HI_RD)
    else $error("operation code treated as transfer");
  chk_len_count: assert property (
    state_reg == S_LO_GET |=> left_reg == {1'b0, $past(len_reg)} + 8'h01)
    else $error("byte count not length plus one");
  chk_addr_msb_first: assert property (
    seq_addr_bytes |=> addr_reg == mk_addr($past(scr_data, 3),
    $past(scr_data, 1)))
    else $error("start address bytes misassembled");
  chk_range_access: assert property (
    rd_issue || wr_pop |=> reg_req_reg.addr == $past(addr_reg)
    && (reg_req_reg.rd || reg_req_reg.wr))
    else $error("register access off its range");
  chk_script_order: assert property (
    state_reg == S_CMD_DEC |=> scr_addr_reg == $past(scr_addr_reg) + 8'h01)
    else $error("script pointer did not advance");
  chk_done_empty: assert property (
    done_reg |-> !fifo_out_valid && !tx_reg.valid && !busy_reg)
    else $error("done while data still buffered");

endmodule

//--- design/esse_fifo.sv
// Purpose: byte fifo between register buffer and nonvolatile array
// Assumes: DEPTH is a power of two
// Notes:   read data, valid and ready all come from flip-flops
`timescale 1ns/1ps
module esse_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_open,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // storage, no reset needed
  logic [PW-1:0] wr_ptr_reg;         // next slot to fill
  logic [PW-1:0] rd_ptr_reg;         // next slot to read
  logic [CW-1:0] cnt_reg;            // words held in mem
  logic [CW-1:0] cnt_next;
  logic in_ready_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;    // registered read stage
  logic push;
  logic pop;
  logic load;

  assign push = in_valid && in_ready_reg;
  assign pop = out_valid_reg && out_ready;
  // refill the output stage whenever it empties or is taken
  assign load = (!out_valid_reg || pop) && (cnt_reg != '0);
  assign cnt_next = cnt_reg + CW'(push) - CW'(load);

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // write port
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers and level; pointers wrap by overflow of a power of two
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (load)
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      cnt_reg <= cnt_next;
    end
  end

  // ready looks ahead one cycle so it can be a flop and stay honest
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      in_ready_reg <= 1'b0;
    else
      in_ready_reg <= in_open && (cnt_next < CW'(DEPTH));
  end

  // output stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end
    else if (load)
    begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem[rd_ptr_reg];
    end
    else if (pop)
      out_valid_reg <= 1'b0;
  end

  // level never passes the depth
  chk_fifo_level_bound: assert property (@(posedge clk)
    disable iff (!reset_n) cnt_reg <= CW'(DEPTH))
    else $error("fifo level above depth");

endmodule

//--- design/esse_pkg.sv
// Purpose: shared constants and carriers of the script engine
// Assumes: byte-wide script, register buffer and nonvolatile array ports
// Notes:   operation code values are plain defaults, adjust per product
package esse_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;       // register buffer address width
  localparam int DATA_W = 8;        // every stored item is one byte
  localparam int SCR_AW = 8;        // script segment address width
  localparam int FIFO_DEPTH = 8;    // words buffered in the data path

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_KIND_POS = 7;  // set: operation, clear: transfer
  localparam int CMD_LEN_W = 7;     // length minus one in low bits

  // ----------------------------------------------------------------
  // operation codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_COMMIT = 8'h80;  // copy buffer to active
  localparam logic [7:0] OP_END = 8'hA0;     // script terminator
  localparam logic [SCR_AW-1:0] SCR_BASE = 8'h00;  // first script byte

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one access to the register buffer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } esse_reg_req_t;

  // one byte offered on a stream
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } esse_byte_t;

endpackage

//--- tb/esse_engine_bench.sv
// Purpose: self-checking bench of the script engine
// Assumes: partner model answers script, register and array ports
// Notes:   expected save and kept bytes come from the bench's own pattern function, loaded bytes count up from C0
`timescale 1ns/1ps
module esse_engine_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0; // held low for six cycles
  logic start = 1'b0;
  logic save_sel = 1'b0;
  logic busy, done, commit, scr_rd, ee_tx_ready, ee_rx_valid, ee_rx_ready;
  logic [esse_pkg::SCR_AW-1:0] scr_addr;
  logic [7:0] scr_data, reg_rdata, ee_rx_data;
  esse_pkg::esse_reg_req_t reg_req;
  esse_pkg::esse_byte_t ee_tx;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0; // hang guard
  logic [7:0] q [$]; // script being loaded

  always #5 clk = ~clk;

  esse_engine #(.DEPTH(8)) DUT (.clk(clk), .reset_n(reset_n),
    .start(start), .save_sel(save_sel), .busy(busy), .done(done),
    .commit(commit), .scr_rd(scr_rd), .scr_addr(scr_addr),
    .scr_data(scr_data), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ee_tx(ee_tx), .ee_tx_ready(ee_tx_ready), .ee_rx_valid(ee_rx_valid),
    .ee_rx_data(ee_rx_data), .ee_rx_ready(ee_rx_ready));

  esse_partner far (.clk(clk), .reset_n(reset_n), .scr_rd(scr_rd),
    .scr_addr(scr_addr), .scr_data(scr_data), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .ee_tx(ee_tx), .ee_tx_ready(ee_tx_ready),
    .ee_rx_valid(ee_rx_valid), .ee_rx_data(ee_rx_data),
    .ee_rx_ready(ee_rx_ready), .commit(commit));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // register contents differ across each 256-address block, so a wrong high address byte shows
  function automatic logic [7:0] pat(input int a);
    logic [11:0] x;
    x = a[11:0];
    return x[7:0] ^ {x[11:8], 4'h0} ^ 8'h5A;
  endfunction

  task chk_byte(input string what, input logic [7:0] exp,
                input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chk_int(input string what, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // script into the partner, ee_got and the write and commit counts cleared
  task load_script;
    for (int i = 0; i < q.size(); i++)
      far.scr_mem[i] = q[i];
    far.ee_got.delete();
    far.n_wr = 0;
    far.n_commit = 0;
  endtask

  // one walk; poke gives a stray start while busy, which must be ignored
  task run(input logic save, input logic poke);
    int k;
    k = 0;
    @(posedge clk);
    start <= 1'b1;
    save_sel <= save;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk_byte("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && k < 4000)
    begin
      @(posedge clk);
      start <= poke && (k == 6);
      #1;
      k++;
    end
    chk_byte("done", 8'h01, {7'h00, done});
    chk_byte("busy", 8'h00, {7'h00, busy});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // two entries around a commit and a skipped unknown op
  task save_mixed;
    q = '{8'h01, 8'h01, 8'h23, 8'h85, 8'h80, 8'h00, 8'h02, 8'h00, 8'hA0};
    load_script;
    run(1'b1, 1'b1);
    chk_int("saved count", 3, far.ee_got.size());
    chk_byte("save 0", pat(12'h123), far.ee_got[0]);
    chk_byte("save 1", pat(12'h124), far.ee_got[1]);
    chk_byte("save 2", pat(12'h200), far.ee_got[2]);
    chk_int("commits", 1, far.n_commit);
    chk_int("writes", 0, far.n_wr);
  endtask

  // longest entry while the array stalls: fifo fills then drains
  task save_full;
    q = '{8'h7F, 8'h03, 8'h00, 8'hA0};
    load_script;
    far.hold = 80;
    run(1'b1, 1'b0);
    chk_int("saved count", 128, far.ee_got.size());
    for (int i = 0; i < 128; i++)
      chk_byte("save long", pat(12'h300 + i), far.ee_got[i]);
    chk_int("commits", 0, far.n_commit);
    chk_byte("rx ready idle", 8'h00, {7'h00, ee_rx_ready});
  endtask

  // load two ranges with a gap between, then commit, from a slow source
  task load_entries;
    q = '{8'h03, 8'h00, 8'h40, 8'h0B, 8'h07, 8'hF0, 8'h80, 8'hA0};
    load_script;
    far.gap = 1'b1;
    for (int i = 0; i < 16; i++)
      far.ee_src.push_back(8'hC0 + i[7:0]);
    run(1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      chk_byte("load a", 8'hC0 + i[7:0], far.regs[12'h040 + i]);
    for (int i = 0; i < 12; i++)
      chk_byte("load b", 8'hC4 + i[7:0], far.regs[12'h7F0 + i]);
    chk_byte("gap kept", pat(12'h044), far.regs[12'h044]);
    chk_byte("tail kept", pat(12'h7FC), far.regs[12'h7FC]);
    chk_int("writes", 16, far.n_wr);
    chk_int("left over", 0, far.ee_src.size());
    chk_int("commits", 1, far.n_commit);
    chk_int("commit last", 1, int'(far.commit_at > far.last_wr));
  endtask

  // reset in mid-walk: busy and commit are low in reset, then a fresh walk works
  task reset_mid;
    @(posedge clk);
    start <= 1'b1;
    save_sel <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_byte("busy in reset", 8'h00, {7'h00, busy});
    chk_byte("commit in reset", 8'h00, {7'h00, commit});
    @(posedge clk);
    reset_n <= 1'b1;
    save_mixed;
  endtask

  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      give_verdict;
    end
  end

  initial
  begin
    for (int a = 0; a < 4096; a++)
      far.regs[a] = pat(a);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    save_mixed;
    save_full;
    load_entries;
    reset_mid;
    give_verdict;
  end
endmodule

//--- tb/esse_partner.sv
// Purpose: far side model: script store, register buffer, array streams
// Assumes: one-cycle read latency on script and register ports
// Notes:   idle read lines show the inverse of their last value
`timescale 1ns/1ps
module esse_partner
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scr_rd,
  input wire logic [esse_pkg::SCR_AW-1:0] scr_addr,
  output logic [7:0] scr_data,
  input wire esse_pkg::esse_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire esse_pkg::esse_byte_t ee_tx,
  output logic ee_tx_ready,
  output logic ee_rx_valid,
  output logic [7:0] ee_rx_data,
  input wire logic ee_rx_ready,
  input wire logic commit
);
  // ------------------------------------------------------------
  // storage and statistics
  // ------------------------------------------------------------
  logic [7:0] scr_mem [256]; // script segment, ends with end op
  logic [7:0] regs [4096]; // register buffer
  logic [7:0] ee_src [$]; // bytes the array still offers
  logic [7:0] ee_got [$]; // bytes the array has taken
  int hold = 0; // cycles the array refuses save bytes
  logic gap = 1'b0; // slow load source when set
  logic gap_t; // gap phase
  int cyc = 0; // cycle count for ordering
  int n_wr = 0; // register writes seen
  int n_commit = 0; // cycles with commit high
  int last_wr = 0; // cycle of last write
  int commit_at = 0; // cycle of last commit

  // script answers one cycle after the strobe, garbage otherwise
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      scr_data <= 8'h00;
    else
      scr_data <= scr_rd ? scr_mem[scr_addr] : ~scr_data;

  // register buffer: reads answer next cycle, writes land at once
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      reg_rdata <= 8'h00;
    else
    begin
      reg_rdata <= reg_req.rd ? regs[reg_req.addr] : ~reg_rdata;
      if (reg_req.wr)
        regs[reg_req.addr] <= reg_req.wdata;
    end

  // one monitor so the cycle stamps never race each other
  always @(posedge clk)
  begin
    cyc++;
    if (reg_req.wr)
    begin
      n_wr++;
      last_wr = cyc;
    end
    if (commit)
    begin
      n_commit++;
      commit_at = cyc;
    end
  end

  // save sink: refuses while hold runs, so the fifo fills up
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      ee_tx_ready <= 1'b0;
    else
    begin
      if (ee_tx.valid && ee_tx_ready)
        ee_got.push_back(ee_tx.data);
      ee_tx_ready <= (hold == 0);
      if (hold > 0)
        hold--;
    end

  // load source: data stands until taken, gaps when slow
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ee_rx_valid <= 1'b0;
      ee_rx_data <= 8'h00;
      gap_t <= 1'b0;
    end
    else
    begin
      gap_t <= ~gap_t;
      if (!ee_rx_valid || ee_rx_ready)
      begin
        if (ee_src.size() > 0 && !(gap && gap_t))
        begin
          ee_rx_valid <= 1'b1;
          ee_rx_data <= ee_src.pop_front();
        end
        else
        begin
          ee_rx_valid <= 1'b0;
          ee_rx_data <= ~ee_rx_data; // released line wanders
        end
      end
    end
endmodule
